//--- shared/smsx_pkg.sv
/*
  Constants and carrier types of the serial master.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
`default_nettype none

package smsx_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_TXSC = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RCSC = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_RPC = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_DIVH = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DIVL = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_TXHB = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_RXHB = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ = 5'h1C;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  // transmit_status_control
  localparam int TX_MASTER_B = 7;
  localparam int TX_NINE_SEL_B = 6;
  localparam int TX_ENABLE_B = 5;
  localparam int TX_SYNC_B = 4;
  localparam int TX_EMPTY_B = 1;
  localparam int TX_NINE_VAL_B = 0;
  localparam logic [7:0] TXSC_WMASK = 8'hF1;
  // receive_status_control
  localparam int RC_PORT_EN_B = 7;
  localparam int RC_NINE_SEL_B = 6;
  localparam int RC_SINGLE_B = 5;
  localparam int RC_CONT_B = 4;
  localparam int RC_FRAME_B = 2;
  localparam int RC_OVER_B = 1;
  localparam int RC_NINE_VAL_B = 0;
  localparam logic [7:0] RCSC_WMASK = 8'hF0;
  // rate_polarity_control
  localparam int RP_DATA_POL_B = 5;
  localparam int RP_CLK_POL_B = 4;
  localparam int RP_WIDE_B = 3;
  localparam logic [7:0] RPC_WMASK = 8'h38;
  // interrupt enable and flag register
  localparam int IRQ_TX_EN_B = 0;
  localparam int IRQ_RX_EN_B = 1;
  localparam int IRQ_TX_FLAG_B = 4;
  localparam int IRQ_RX_FLAG_B = 5;
  localparam logic [7:0] IRQ_WMASK = 8'h03;

  // ---------------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SMSX_IDLE = 2'b00,
    SMSX_LOAD = 2'b01,
    SMSX_TX = 2'b10,
    SMSX_RX = 2'b11
  } smsx_mode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } smsx_baud_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } smsx_bus_t;

  typedef struct packed {
    smsx_bus_t bus;
    logic [7:0] txsc;
    logic [7:0] rcsc;
    logic [7:0] rpc;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic [7:0] irq_en;
    logic hold_full;
    logic tbe_flag;
    logic rc_flag;
    logic overrun;
    logic rx_nine;
    smsx_mode_t mode;
    logic [8:0] shifter;
    logic [3:0] bit_cnt;
    logic phase;
    logic ck_pin;
    logic dt_pin;
    logic dt_oe_n;
    logic tx_irq;
    logic rx_irq;
  } smsx_state_t;

endpackage : smsx_pkg

`default_nettype wire

//--- src/smsx_sync2.sv
/*
  Two-flop synchroniser for a level arriving from a pin.
  Assumes the level may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module smsx_sync2
  import smsx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);

  // ---------------------------------------------------------------------
  // Two stages; only the second stage is visible
  // ---------------------------------------------------------------------
  logic [1:0] stage_q;
  logic [1:0] stage_d;

  // Shift the pin level through both stages
  always_comb begin
    stage_d = {stage_q[0], async_in};
  end

  // Register the stages
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage_q <= 2'h0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sync_out = stage_q[1];

endmodule : smsx_sync2

`default_nettype wire

//--- src/smsx_baud.sv
/*
  Rate generator: one tick every (divisor + 1) clock cycles while running.
  Assumes the divisor is steady while a word is being shifted.
*/
`timescale 1ns/1ps
`default_nettype none

module smsx_baud
  import smsx_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [DIV_W-1:0] divisor_in,
  output logic tick_out
);

  // ---------------------------------------------------------------------
  // Down counter with reload
  // ---------------------------------------------------------------------
  smsx_baud_t st_q;
  smsx_baud_t st_d;

  // Count down; reload and pulse at zero, hold loaded while stopped
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_in) begin
      st_d.cnt = 16'(divisor_in);
    end else if (st_q.cnt == 16'h0000) begin
      st_d.cnt = 16'(divisor_in);
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
  end

  // Register the counter
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_out = st_q.tick;

endmodule : smsx_baud

`default_nettype wire

//--- src/smsx_master.sv
/*
  Synchronous serial master with an AXI4-Lite register slave.
  Drives the shift clock; words go out least significant bit first
  on a shared, half-duplex data pin.
  Assumes one clock, synchronous active-low reset, outside pin resolver.
*/
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01 - Reload shifter only after its last bit
// R02 - Transfer takes one cycle, sets empty flag
// R03 - Empty flag cleared only by buffer write
// R04 - Transmit request gated by its enable
// R05 - Shifter-empty status readable at bit 1
// R06 - Shifter-empty status drives no interrupt
// R07 - Shift register is never bus-addressable
// R08 - Software sets sync, port, master bits
// R09 - Software programs divisor and width select
// R10 - Nine-bit words take ninth from register
// R11 - Buffer write starts transmission when enabled
// R12 - Either receive enable starts reception
// R13 - Data sampled as clock returns idle
// R14 - Single enable receives exactly one word
// R15 - Continuous enable receives until cleared
// R16 - Both enables set behaves as continuous
// R17 - Polarity bits invert clock and data
// R18 - Receive flag set; request gated by enable
// R19 - Ninth received bit and errors in status
// R20 - Low eight bits in receive buffer
// R21 - Clearing continuous enable clears errors
// R22 - Software clears enables before configuring
// R23 - Polarity bits select pin idle levels
// R24 - Transmit and receive never overlap
// R25 - Clock pin toggles only during transfers
module smsx_master
  import smsx_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic SHIFT_CLOCK_PIN_OUT,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE_N_OUT,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic TX_IRQ_OUT,
  output logic RX_IRQ_OUT
);

  // ---------------------------------------------------------------------
  // State and helpers
  // ---------------------------------------------------------------------
  smsx_state_t q;
  smsx_state_t d;
  logic data_sync;
  logic tick;
  logic run;
  logic [15:0] divisor;

  // Divisor width select: low byte alone or both bytes
  assign divisor = q.rpc[RP_WIDE_B] ? {q.div_hi, q.div_lo}
                                    : {8'h00, q.div_lo};
  assign run = (q.mode == SMSX_TX) || (q.mode == SMSX_RX);

  // Data pin level, passed through two flops before use
  smsx_sync2 u_data_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .async_in(SERIAL_DATA_PIN_IN),
    .sync_out(data_sync)
  );

  // Half-bit tick source for the shift clock
  smsx_baud #(
    .DIV_W(16)
  ) u_baud (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .run_in(run),
    .divisor_in(divisor),
    .tick_out(tick)
  );

  // ---------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------
  function automatic logic [8:0] read_reg(input smsx_state_t s,
                                          input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    logic ok;
    v = 8'h00;
    ok = 1'b1;
    unique case (a)
      // R05 shifter-empty status
      ADDR_TXSC: begin
        v = s.txsc;
        v[TX_EMPTY_B] = (s.mode != SMSX_TX) && (s.mode != SMSX_LOAD);
      end
      // R19 ninth bit, errors
      ADDR_RCSC: begin
        v = s.rcsc;
        v[RC_OVER_B] = s.overrun;
        v[RC_NINE_VAL_B] = s.rx_nine;
      end
      ADDR_RPC: v = s.rpc;
      ADDR_DIVH: v = s.div_hi;
      ADDR_DIVL: v = s.div_lo;
      ADDR_TXHB: v = s.tx_hold;
      // R20 low eight bits
      ADDR_RXHB: v = s.rx_hold;
      ADDR_IRQ: begin
        v = s.irq_en;
        v[IRQ_TX_FLAG_B] = s.tbe_flag;
        v[IRQ_RX_FLAG_B] = s.rc_flag;
      end
      // R07 shifter has no address
      default: ok = 1'b0;
    endcase
    return {ok, v};
  endfunction : read_reg

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    logic [8:0] rd;
    logic rx_clear;
    logic port_on;
    logic rx_bit;
    logic [8:0] sh;
    logic [3:0] nbits;
    logic tx_ready;
    logic rx_want;
    logic clk_idle;
    logic dt_idle;
    do_write = 1'b0;
    do_read = 1'b0;
    rd = 9'h000;
    rx_clear = 1'b0;
    port_on = 1'b0;
    rx_bit = 1'b0;
    sh = 9'h000;
    nbits = BITS_EIGHT;
    tx_ready = 1'b0;
    rx_want = 1'b0;
    clk_idle = 1'b0;
    dt_idle = 1'b0;
    d = q;

    // Bus write: hold address and data until both arrived
    if (q.bus.awready && S_AXI_AWVALID_IN) begin
      d.bus.aw_have = 1'b1;
      d.bus.aw_addr = S_AXI_AWADDR_IN;
    end
    if (q.bus.wready && S_AXI_WVALID_IN) begin
      d.bus.w_have = 1'b1;
      d.bus.w_data = S_AXI_WDATA_IN[7:0];
      d.bus.w_lane = S_AXI_WSTRB_IN[0];
    end
    if (q.bus.bvalid && S_AXI_BREADY_IN) begin
      d.bus.bvalid = 1'b0;
    end
    if (q.bus.aw_have && q.bus.w_have && !q.bus.bvalid) begin
      do_write = 1'b1;
      d.bus.aw_have = 1'b0;
      d.bus.w_have = 1'b0;
      d.bus.bvalid = 1'b1;
      rd = read_reg(q, q.bus.aw_addr);
      d.bus.bresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
    end
    d.bus.awready = !d.bus.aw_have && !d.bus.bvalid;
    d.bus.wready = !d.bus.w_have && !d.bus.bvalid;

    // Bus read: one outstanding, answered the cycle after acceptance
    if (q.bus.rvalid && S_AXI_RREADY_IN) begin
      d.bus.rvalid = 1'b0;
    end
    if (q.bus.arready && S_AXI_ARVALID_IN) begin
      do_read = 1'b1;
      rd = read_reg(q, S_AXI_ARADDR_IN);
      d.bus.rvalid = 1'b1;
      d.bus.rdata = {24'h000000, rd[7:0]};
      d.bus.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
      rx_clear = (S_AXI_ARADDR_IN == ADDR_RXHB);
    end
    d.bus.arready = !d.bus.rvalid && !do_read;

    // Register writes; only byte lane 0 carries register bits
    if (do_write && q.bus.w_lane) begin
      unique case (q.bus.aw_addr)
        ADDR_TXSC: d.txsc = q.bus.w_data & TXSC_WMASK;
        ADDR_RCSC: begin
          d.rcsc = q.bus.w_data & RCSC_WMASK;
          // R21 error clear
          if (!q.bus.w_data[RC_CONT_B]) begin
            d.overrun = 1'b0;
          end
        end
        ADDR_RPC: d.rpc = q.bus.w_data & RPC_WMASK;
        ADDR_DIVH: d.div_hi = q.bus.w_data;
        ADDR_DIVL: d.div_lo = q.bus.w_data;
        // R03 only a buffer write clears it
        ADDR_TXHB: begin
          d.tx_hold = q.bus.w_data;
          d.hold_full = 1'b1;
          d.tbe_flag = 1'b0;
        end
        ADDR_IRQ: d.irq_en = q.bus.w_data & IRQ_WMASK;
        default: d.txsc = q.txsc;
      endcase
    end

    // Reading the receive buffer retires the receive flag
    if (rx_clear) begin
      d.rc_flag = 1'b0;
    end

    // R17 polarity of pins; R23 idle levels
    clk_idle = q.rpc[RP_CLK_POL_B];
    dt_idle = q.rpc[RP_DATA_POL_B];
    rx_bit = data_sync ^ q.rpc[RP_DATA_POL_B];
    port_on = q.rcsc[RC_PORT_EN_B] && q.txsc[TX_SYNC_B]
              && q.txsc[TX_MASTER_B];
    // R11 start condition
    tx_ready = q.hold_full && q.txsc[TX_ENABLE_B];
    // R12 either enable
    rx_want = q.rcsc[RC_SINGLE_B] || q.rcsc[RC_CONT_B];

    // Shift engine
    unique case (q.mode)
      SMSX_IDLE: begin
        d.ck_pin = clk_idle;
        d.phase = 1'b0;
        d.bit_cnt = 4'h0;
        if (port_on && tx_ready) begin
          d.mode = SMSX_LOAD;
        // R24 receive only with nothing to send
        end else if (port_on && rx_want) begin
          d.mode = SMSX_RX;
          d.dt_oe_n = 1'b1;
        end else begin
          d.dt_oe_n = !port_on;
          d.dt_pin = dt_idle;
        end
      end
      // R02 one-cycle transfer, buffer empty
      SMSX_LOAD: begin
        // R10 ninth bit from register
        d.shifter = {q.txsc[TX_NINE_VAL_B], q.tx_hold};
        d.hold_full = 1'b0;
        d.tbe_flag = 1'b1;
        d.dt_oe_n = 1'b0;
        d.dt_pin = q.tx_hold[0] ^ dt_idle;
        d.bit_cnt = 4'h0;
        d.phase = 1'b0;
        d.mode = SMSX_TX;
      end
      SMSX_TX: begin
        nbits = q.txsc[TX_NINE_SEL_B] ? BITS_NINE : BITS_EIGHT;
        if (!port_on) begin
          d.mode = SMSX_IDLE;
        end else if (tick && !q.phase) begin
          // R25 clock active half
          d.ck_pin = !clk_idle;
          d.phase = 1'b1;
        end else if (tick) begin
          d.ck_pin = clk_idle;
          d.phase = 1'b0;
          sh = {1'b0, q.shifter[8:1]};
          d.shifter = sh;
          d.bit_cnt = q.bit_cnt + 4'h1;
          d.dt_pin = sh[0] ^ dt_idle;
          if (q.bit_cnt == nbits - 4'h1) begin
            // R01 reload only after last bit
            d.mode = tx_ready ? SMSX_LOAD : SMSX_IDLE;
            d.dt_pin = dt_idle;
          end
        end
      end
      SMSX_RX: begin
        nbits = q.rcsc[RC_NINE_SEL_B] ? BITS_NINE : BITS_EIGHT;
        d.dt_oe_n = 1'b1;
        if (!port_on || !rx_want) begin
          d.mode = SMSX_IDLE;
          d.ck_pin = clk_idle;
        end else if (tick && !q.phase) begin
          // R25 clock active half
          d.ck_pin = !clk_idle;
          d.phase = 1'b1;
        end else if (tick) begin
          // R13 sample as clock returns idle
          d.ck_pin = clk_idle;
          d.phase = 1'b0;
          sh = {rx_bit, q.shifter[8:1]};
          d.shifter = sh;
          d.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == nbits - 4'h1) begin
            d.bit_cnt = 4'h0;
            if (q.rc_flag && !rx_clear) begin
              d.overrun = 1'b1;
            end else begin
              // R18 completion flag; R19 ninth; R20 low byte
              d.rc_flag = 1'b1;
              d.rx_hold = q.rcsc[RC_NINE_SEL_B] ? sh[7:0] : sh[8:1];
              d.rx_nine = q.rcsc[RC_NINE_SEL_B] ? sh[8] : 1'b0;
            end
            // R15 continuous keeps going; R16 it wins
            if (!q.rcsc[RC_CONT_B]) begin
              // R14 single word then stop
              d.rcsc[RC_SINGLE_B] = 1'b0;
              d.mode = SMSX_IDLE;
            end
          end
        end
      end
      default: d.mode = SMSX_IDLE;
    endcase

    // R04 transmit request gated; R18 receive request gated; R06 no
    // shifter-empty source
    d.tx_irq = d.tbe_flag && d.irq_en[IRQ_TX_EN_B];
    d.rx_irq = d.rc_flag && d.irq_en[IRQ_RX_EN_B];
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      q <= '0;
      q.txsc <= REG_RESET;
      q.rcsc <= REG_RESET;
      q.rpc <= REG_RESET;
      q.irq_en <= REG_RESET;
      q.tbe_flag <= 1'b1;
      q.dt_oe_n <= 1'b1;
      q.mode <= SMSX_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------------
  assign S_AXI_AWREADY_OUT = q.bus.awready;
  assign S_AXI_WREADY_OUT = q.bus.wready;
  assign S_AXI_BRESP_OUT = q.bus.bresp;
  assign S_AXI_BVALID_OUT = q.bus.bvalid;
  assign S_AXI_ARREADY_OUT = q.bus.arready;
  assign S_AXI_RDATA_OUT = q.bus.rdata;
  assign S_AXI_RRESP_OUT = q.bus.rresp;
  assign S_AXI_RVALID_OUT = q.bus.rvalid;
  assign SHIFT_CLOCK_PIN_OUT = q.ck_pin;
  assign SERIAL_DATA_PIN_OUT = q.dt_pin;
  assign SERIAL_DATA_PIN_OE_N_OUT = q.dt_oe_n;
  assign TX_IRQ_OUT = q.tx_irq;
  assign RX_IRQ_OUT = q.rx_irq;

endmodule : smsx_master

`default_nettype wire

//--- verification/smsx_master_monitor.sv
/*
  Checker for the serial master: bus answers, pin timing, requests.
  Assumes it is bound to smsx_master and sees that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module smsx_master_monitor (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic S_AXI_AWVALID_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WVALID_IN,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic SHIFT_CLOCK_PIN_OUT,
  input wire logic TX_IRQ_OUT,
  input wire logic RX_IRQ_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  logic [3:0] bv_q;
  logic [3:0] rv_q;

  // Recent bus answers, which alone may lower a request
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      bv_q <= 4'h0;
      rv_q <= 4'h0;
    end else begin
      bv_q <= {bv_q[2:0], S_AXI_BVALID_OUT};
      rv_q <= {rv_q[2:0], S_AXI_RVALID_OUT};
    end
  end

  // Bus steps
  sequence wr_taken_s;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
      S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  endsequence
  sequence rd_taken_s;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  endsequence

  write_answer_a: assert property (wr_taken_s |-> ##[1:2] S_AXI_BVALID_OUT)
    else $error("write not answered");
  read_answer_a: assert property (rd_taken_s |-> ##[1:2] S_AXI_RVALID_OUT)
    else $error("read not answered");
  write_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
    |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write answer dropped");
  read_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped");
  rdata_high_a: assert property (S_AXI_RVALID_OUT
    |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
    else $error("read data above byte");
  clk_hold_a: assert property ($changed(SHIFT_CLOCK_PIN_OUT)
    |=> $stable(SHIFT_CLOCK_PIN_OUT) [*2])
    else $error("shift clock half too short");
  tx_irq_fall_a: assert property ($fell(TX_IRQ_OUT)
    |-> (|bv_q) || S_AXI_BVALID_OUT)
    else $error("tx request fell unasked");
  rx_irq_fall_a: assert property ($fell(RX_IRQ_OUT)
    |-> (|rv_q) || (|bv_q) || S_AXI_RVALID_OUT)
    else $error("rx request fell unasked");
endmodule : smsx_master_monitor

`default_nettype wire

//--- verification/smsx_slave_model.sv
/*
  Behavioural synchronous slave on the shift clock and data pins.
  Assumes the bench resolves the shared data wire from the enable.
*/
`timescale 1ns/1ps
`default_nettype none

module smsx_slave_model (
  input wire logic ck_in,
  input wire logic dt_in,
  input wire logic oe_n_in,
  input wire logic ck_pol_in,
  input wire logic dt_pol_in,
  input wire logic [8:0] word_in,
  input wire logic [3:0] nbits_in,
  output logic dt_out
);
  logic cap_q[$];
  logic [3:0] idx = 4'h0;
  int sent = 0;

  initial dt_out = 1'h0;

  // Word restarts when the master turns the wire round
  always @(posedge oe_n_in) begin
    idx = 4'h0;
  end

  // Drive or capture mid-bit as the clock leaves idle
  always @(ck_in) begin
    if (ck_in !== ck_pol_in) begin
      if (oe_n_in) dt_out = word_in[idx] ^ dt_pol_in;
      else cap_q.push_back(dt_in ^ dt_pol_in);
    end else if (oe_n_in) begin
      idx = (idx + 4'h1 == nbits_in) ? 4'h0 : idx + 4'h1;
      if (idx == 4'h0) sent++;
    end
  end
endmodule : smsx_slave_model

`default_nettype wire

//--- verification/testbench.sv
/*
  Self-checking bench: register bus, transmission and reception.
  Assumes divisor 7, giving a 160 ns shift clock at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import smsx_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, aw_valid = 1'h0, w_valid = 1'h0;
  logic b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
  logic [ADDR_W-1:0] aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0, r_data, rdv;
  logic [3:0] w_strb = 4'hF;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp, rsp;
  logic ck, dt_o, dt_oe_n, dt_slv, tx_irq, rx_irq;
  logic ck_pol = 1'h0, dt_pol = 1'h0;
  logic [8:0] slv_word = 9'h000;
  logic [3:0] slv_bits = 4'h8;
  int n_mismatch = 0, checks = 0, seed = 21735;
  wire dt_wire;

  // Master drives the wire while its enable is low
  assign dt_wire = dt_oe_n ? dt_slv : dt_o;

  smsx_master dut_u (
    .CORE_CLK_IN(clk), .RESETN_IN(rst_n),
    .S_AXI_AWADDR_IN(aw_addr), .S_AXI_AWVALID_IN(aw_valid),
    .S_AXI_AWREADY_OUT(aw_ready), .S_AXI_WDATA_IN(w_data),
    .S_AXI_WSTRB_IN(w_strb), .S_AXI_WVALID_IN(w_valid),
    .S_AXI_WREADY_OUT(w_ready), .S_AXI_BRESP_OUT(b_resp),
    .S_AXI_BVALID_OUT(b_valid), .S_AXI_BREADY_IN(b_ready),
    .S_AXI_ARADDR_IN(ar_addr), .S_AXI_ARVALID_IN(ar_valid),
    .S_AXI_ARREADY_OUT(ar_ready), .S_AXI_RDATA_OUT(r_data),
    .S_AXI_RRESP_OUT(r_resp), .S_AXI_RVALID_OUT(r_valid),
    .S_AXI_RREADY_IN(r_ready), .SHIFT_CLOCK_PIN_OUT(ck),
    .SERIAL_DATA_PIN_OUT(dt_o), .SERIAL_DATA_PIN_OE_N_OUT(dt_oe_n),
    .SERIAL_DATA_PIN_IN(dt_wire), .TX_IRQ_OUT(tx_irq),
    .RX_IRQ_OUT(rx_irq)
  );

  smsx_slave_model slave_u (
    .ck_in(ck), .dt_in(dt_wire), .oe_n_in(dt_oe_n), .ck_pol_in(ck_pol),
    .dt_pol_in(dt_pol), .word_in(slv_word), .nbits_in(slv_bits),
    .dt_out(dt_slv)
  );

  // Core clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Bus write; answer kept in rsp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    aw_addr <= a;
    aw_valid <= 1'h1;
    w_data <= 32'(d);
    w_valid <= 1'h1;
    b_ready <= 1'h1;
    do begin
      @(posedge clk);
      if (aw_ready === 1'h1) aw_valid <= 1'h0;
      if (w_ready === 1'h1) w_valid <= 1'h0;
    end while (b_valid !== 1'h1);
    rsp = b_resp;
    b_ready <= 1'h0;
    @(posedge clk);
  endtask : wr

  // Bus read; data kept in rdv
  task automatic rd(input logic [ADDR_W-1:0] a);
    ar_addr <= a;
    ar_valid <= 1'h1;
    r_ready <= 1'h1;
    do begin
      @(posedge clk);
      if (ar_ready === 1'h1) ar_valid <= 1'h0;
    end while (r_valid !== 1'h1);
    rdv = r_data;
    r_ready <= 1'h0;
    @(posedge clk);
  endtask : rd

  task automatic wait_rx;
    for (int i = 0; i < 3000 && rx_irq !== 1'h1; i++) @(posedge clk);
  endtask : wait_rx

  // Captured word rebuilt, first bit lowest
  function automatic logic [8:0] take(input int n);
    logic [8:0] v;
    v = 9'h000;
    for (int i = 0; i < n; i++) v[i] = slave_u.cap_q.pop_front();
    return v;
  endfunction : take

  // Receive status expected from enables and ninth bit
  function automatic logic [31:0] exp_rc(input logic [7:0] c, input logic n);
    return {24'h000000, c[7:4], 3'h0, n};
  endfunction : exp_rc

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    int i, k, x;
    logic [7:0] a, b;
    logic [8:0] w;
    logic nine, pol;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(ADDR_TXSC);
    chk(rdv, 32'h00000002);
    rd(ADDR_IRQ);
    chk(rdv, 32'h00000010);
    wr(5'h1E, 8'hFF);
    chk(rsp, RESP_SLVERR);
    $display("test reset done");
    wr(ADDR_DIVL, 8'h07);
    wr(ADDR_RCSC, 8'h80);
    wr(ADDR_IRQ, 8'h01);
    // Plain, nine-bit and inverted words, back to back
    for (k = 0; k < 3; k++) begin
      nine = (k == 1);
      pol = (k == 2);
      dt_pol = pol;
      ck_pol = pol;
      wr(ADDR_RPC, {2'h0, pol, pol, 4'h0});
      wr(ADDR_TXSC, {1'h1, nine, 6'h31});
      repeat (4) @(posedge clk);
      chk(ck, pol);
      chk(dt_o, pol);
      slave_u.cap_q.delete();
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(ADDR_TXHB, a);
      wr(ADDR_TXHB, b);
      @(posedge clk);
      chk(tx_irq, 1'h0);
      for (i = 0; i < 300; i++) begin
        rd(ADDR_TXSC);
        if (rdv[TX_EMPTY_B] === 1'h1) break;
      end
      chk(tx_irq, 1'h1);
      chk(slave_u.cap_q.size(), nine ? 18 : 16);
      chk(take(nine ? 9 : 8), {nine, a});
      chk(take(nine ? 9 : 8), {nine, b});
      $display("test transmit %0d done", k);
    end
    wr(ADDR_IRQ, 8'h02);
    @(posedge clk);
    chk(tx_irq, 1'h0);
    rd(ADDR_IRQ);
    chk(rdv, 32'h00000012);
    wr(ADDR_RPC, 8'h00);
    ck_pol = 1'h0;
    dt_pol = 1'h0;
    // Single reception
    w = 9'($random(seed));
    slv_word = w;
    slave_u.sent = 0;
    wr(ADDR_RCSC, 8'hA0);
    wait_rx();
    chk(rx_irq, 1'h1);
    rd(ADDR_RCSC);
    chk(rdv & 32'hFE, exp_rc(8'h80, 1'h0));
    rd(ADDR_RXHB);
    chk(rdv, {24'h000000, w[7:0]});
    repeat (2) @(posedge clk);
    chk(rx_irq, 1'h0);
    repeat (400) @(posedge clk);
    chk(slave_u.sent, 1);
    // Continuous nine-bit reception with both enables
    slv_bits = 4'h9;
    w = 9'($random(seed));
    slv_word = w;
    wr(ADDR_RCSC, 8'hF0);
    for (i = 0; i < 3; i++) begin
      wait_rx();
      rd(ADDR_RCSC);
      chk(rdv & 32'hDF, exp_rc(8'hD0, w[8]));
      rd(ADDR_RXHB);
      chk(rdv, {24'h000000, w[7:0]});
      repeat (3) @(posedge clk);
    end
    // Unread words overrun; clearing the enable clears it
    x = slave_u.sent;
    for (i = 0; i < 2000 && slave_u.sent < x + 2; i++) @(posedge clk);
    repeat (10) @(posedge clk);
    rd(ADDR_RCSC);
    chk(rdv[RC_OVER_B], 1'h1);
    wr(ADDR_RCSC, 8'hC0);
    rd(ADDR_RCSC);
    chk(rdv & 32'hFE, 32'h000000C0);
    repeat (200) @(posedge clk);
    x = slave_u.sent;
    repeat (300) @(posedge clk);
    chk(slave_u.sent, x);
    $display("test receive done");
    summarize();
  end
endmodule : testbench

bind smsx_master smsx_master_monitor mon_u (.*);

`default_nettype wire
